// [verilog/host_brg_defines.svh]
// Register offsets, field positions and timing constants for the host collision/baud block
`ifndef HOST_BRG_DEFINES_SVH
`define HOST_BRG_DEFINES_SVH
// Byte addresses on the register bus
`define A_STATUS   8'h00
`define A_RELOAD   8'h04
`define A_SHIFT    8'h08
`define A_CTRL     8'h0c
`define A_IRQ_STAT 8'h10
`define A_IRQ_MASK 8'h14
// serial_port_status fields
`define ST_SMP     7
`define ST_CKE     6
`define ST_STOP    4
`define ST_START   3
`define ST_BF      0
`define ST_WMASK   8'hc0
`define ST_RESET   8'h00
// Control fields
`define C_RSTART   0
`define C_STOP     1
`define C_PEN      2
// Interrupt status fields
`define I_BCOL     0
`define I_DONE     1
`define I_WIDTH    2
// Baud counter: one rollover is two counts per reload step, period 4*(reload+1)
`define BRG_W      9
`define BRG_ZERO   9'h000
// Pin synchroniser delay, taken off the free-running high phase
`define SYNC_LAT   9'h002
`define BIT_LAST   3'h7
`define RESP_OKAY  2'b00
`define RESP_SLV   2'b10
`endif

// [verilog/host_brg_pkg.sv]
// Types for the host collision and baud generator block
package host_brg_pkg;
  typedef enum logic [11:0] {
    S_IDLE   = 12'h001,
    S_RS_REL = 12'h002,
    S_RS_CNT = 12'h004,
    S_RS_SCL = 12'h008,
    S_RS_HLD = 12'h010,
    S_RS_LOW = 12'h020,
    S_SP_SDA = 12'h040,
    S_SP_SCL = 12'h080,
    S_SP_CNT = 12'h100,
    S_SP_REL = 12'h200,
    S_TX_LO  = 12'h400,
    S_TX_HI  = 12'h800
  } seq_state_t;

  typedef struct packed {
    seq_state_t  st;
    logic [8:0]  brg;
    logic [2:0]  bitn;
    logic [7:0]  status;
    logic [7:0]  reload;
    logic [7:0]  shift;
    logic [2:0]  ctrl;
    logic [1:0]  irq_st;
    logic [1:0]  irq_mask;
    logic        irq;
    logic [1:0]  scl_sy;
    logic [1:0]  sda_sy;
    logic        scl_oe_n;
    logic        sda_oe_n;
    logic        aw_hold;
    logic [7:0]  aw_addr;
    logic        w_hold;
    logic [31:0] wdata;
    logic        wstrb0;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } blk_state_t;
endpackage : host_brg_pkg

// [verilog/host_collision_brg.sv]
// Two-wire host: repeated start / stop collision checks and shared baud counter
// What this block does
// - Repeated start: data low at clock rise collides
// - Repeated start: clock falls before data driven
// - Load, count, release clock, sample data high
// - Data high: reload; early data fall is fine
// - Clock fall before expiry, data undriven: collision
// - Both high: drive data, reload, then clock low
// - Stop: data low, release clock, then count
// - Stop: data low after count expiry collides
// - Stop: clock low before data high collides
// - One baud counter, reload from software register
// - Shift buffer write starts counter automatically
// - Counter stops when done; clock holds level
// - Counter reloaded twice per bus clock period
// - Bus clock is oscillator over 4*(reload+1)
// - Status layout; top two bits writable; reset zero
// - Collision sets flag and returns port idle
// - Collision aborts sequence, releases lines, clears start and stop requests
`timescale 1ns/1ps
`default_nettype none
`include "host_brg_defines.svh"
module host_collision_brg (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  // AXI4-Lite write response
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Open-drain bus lines
  input  wire logic        scl_i,
  output var  logic        scl_o,
  output var  logic        scl_oe_n,
  input  wire logic        sda_i,
  output var  logic        sda_o,
  output var  logic        sda_oe_n,
  // Interrupt
  output var  logic        irq
);
  import host_brg_pkg::*;

  blk_state_t q, d;
  logic       scl_s, sda_s, expired, coll, done, rd_irq;
  logic [8:0] brg_load;

  // Map an address to a known register
  function automatic logic mapped(input logic [7:0] a);
    if (a == `A_STATUS) begin
      return 1'b1;
    end else if (a == `A_RELOAD) begin
      return 1'b1;
    end else if (a == `A_SHIFT) begin
      return 1'b1;
    end else if (a == `A_CTRL) begin
      return 1'b1;
    end else if (a == `A_IRQ_STAT) begin
      return 1'b1;
    end else if (a == `A_IRQ_MASK) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction : mapped

  // Level of a data bit, counted from the top (MSB first)
  function automatic logic bit_at(input logic [7:0] b, input logic [2:0] n);
    return b[`BIT_LAST - n];
  endfunction : bit_at

  // Read word for an address; unmapped and unused bits read zero
  function automatic logic [31:0] read_reg(input logic [7:0] a, input blk_state_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (a == `A_STATUS) begin
      w[7:0] = s.status;
    end else if (a == `A_RELOAD) begin
      w[7:0] = s.reload;
    end else if (a == `A_SHIFT) begin
      w[7:0] = s.shift;
    end else if (a == `A_CTRL) begin
      w[2:0] = s.ctrl;
    end else if (a == `A_IRQ_STAT) begin
      w[1:0] = s.irq_st;
    end else if (a == `A_IRQ_MASK) begin
      w[1:0] = s.irq_mask;
    end
    return w;
  endfunction : read_reg

  assign scl_s    = q.scl_sy[1];
  assign sda_s    = q.sda_sy[1];
  assign expired  = (q.brg == `BRG_ZERO);
  // Two counts per reload step gives a rollover of 2*(reload+1) cycles
  assign brg_load = {q.reload, 1'b1};

  always_comb begin
    d      = q;
    coll   = 1'b0;
    done   = 1'b0;
    rd_irq = 1'b0;
    // Pin levels are asynchronous: two flops before any logic sees them
    d.scl_sy = {q.scl_sy[0], scl_i};
    d.sda_sy = {q.sda_sy[0], sda_i};
    if (!expired) begin
      d.brg = q.brg - 9'h001;
    end

    // ---------------- Register bus ----------------
    if (s_axi_awvalid && q.awready) begin
      d.aw_hold = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_hold = 1'b1;
      d.wdata  = s_axi_wdata;
      d.wstrb0 = s_axi_wstrb[0];
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    // Address and data may arrive in either order
    if (q.aw_hold && q.w_hold && !q.bvalid) begin
      d.aw_hold = 1'b0;
      d.w_hold  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = mapped(q.aw_addr) ? `RESP_OKAY : `RESP_SLV;
      if (q.wstrb0) begin
        if (q.aw_addr == `A_STATUS) begin
          d.status = (q.status & ~`ST_WMASK) | (q.wdata[7:0] & `ST_WMASK);
        end else if (q.aw_addr == `A_RELOAD) begin
          d.reload = q.wdata[7:0];
        end else if (q.aw_addr == `A_SHIFT) begin
          // Writes while a sequence runs are dropped, buffer unchanged
          if (q.st == S_IDLE && q.ctrl[`C_PEN]) begin
            d.shift             = q.wdata[7:0];
            d.status[`ST_BF]    = 1'b1;
            d.st                = S_TX_LO;
            d.bitn              = 3'h0;
            d.scl_oe_n          = 1'b0;
            d.sda_oe_n          = bit_at(q.wdata[7:0], 3'h0);
            d.brg               = brg_load;
          end
        end else if (q.aw_addr == `A_CTRL) begin
          d.ctrl = q.wdata[2:0];
        end else if (q.aw_addr == `A_IRQ_MASK) begin
          d.irq_mask = q.wdata[1:0];
        end
      end
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp  = mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLV;
      d.rdata  = read_reg(s_axi_araddr, q);
      // Reading the interrupt status clears it further down
      rd_irq   = (s_axi_araddr == `A_IRQ_STAT);
    end

    // ---------------- Sequencer ----------------
    case (q.st)
      S_IDLE: begin
        // Counter runs down to zero and stays there; lines keep their last level
        if (q.ctrl[`C_PEN] && q.ctrl[`C_RSTART]) begin
          d.st       = S_RS_REL;
          d.sda_oe_n = 1'b1;
        end else if (q.ctrl[`C_PEN] && q.ctrl[`C_STOP]) begin
          d.st       = S_SP_SDA;
          d.sda_oe_n = 1'b0;
        end
      end
      S_RS_REL: begin
        if (sda_s) begin
          d.brg = brg_load;
          d.st  = S_RS_CNT;
        end
      end
      S_RS_CNT: begin
        if (expired) begin
          d.scl_oe_n = 1'b1;
          d.st       = S_RS_SCL;
        end
      end
      S_RS_SCL: begin
        // Clock arbitration: wait while anyone holds the clock low
        if (scl_s) begin
          if (!sda_s) begin
            coll = 1'b1;
          end else begin
            d.brg = brg_load;
            d.st  = S_RS_HLD;
          end
        end
      end
      S_RS_HLD: begin
        // Clock taken low before our data fell: another host sends a one
        if (!scl_s && sda_s) begin
          coll = 1'b1;
        end else if (expired || !sda_s) begin
          // Early data fall from another host is not a collision
          d.sda_oe_n = 1'b0;
          d.brg      = brg_load;
          d.st       = S_RS_LOW;
        end
      end
      S_RS_LOW: begin
        if (expired) begin
          d.scl_oe_n               = 1'b0;
          d.status[`ST_START]      = 1'b1;
          d.status[`ST_STOP]       = 1'b0;
          d.ctrl[`C_RSTART]        = 1'b0;
          done                     = 1'b1;
          d.st                     = S_IDLE;
        end
      end
      S_SP_SDA: begin
        if (!sda_s) begin
          d.scl_oe_n = 1'b1;
          d.st       = S_SP_SCL;
        end
      end
      S_SP_SCL: begin
        if (scl_s) begin
          d.brg = brg_load;
          d.st  = S_SP_CNT;
        end
      end
      S_SP_CNT: begin
        // Clock stolen while we count: another host drives it
        if (!scl_s) begin
          coll = 1'b1;
        end else if (expired) begin
          d.sda_oe_n = 1'b1;
          d.brg      = brg_load;
          d.st       = S_SP_REL;
        end
      end
      S_SP_REL: begin
        if (!scl_s && !sda_s) begin
          coll = 1'b1;
        end else if (expired) begin
          // Data still low after expiry: another host drives a zero
          if (!sda_s) begin
            coll = 1'b1;
          end else begin
            d.status[`ST_STOP]  = 1'b1;
            d.status[`ST_START] = 1'b0;
            d.ctrl[`C_STOP]     = 1'b0;
            done                = 1'b1;
            d.st                = S_IDLE;
          end
        end
      end
      S_TX_LO: begin
        if (expired) begin
          d.scl_oe_n = 1'b1;
          // Shortened load: the synchroniser delay belongs to the high phase
          d.brg      = brg_load - `SYNC_LAT;
          d.st       = S_TX_HI;
        end
      end
      S_TX_HI: begin
        // A held-low clock (stretching) keeps the high phase from starting;
        // the count is frozen, so a stretch delays but never shortens it
        if (!scl_s) begin
          d.brg = q.brg;
        end else if (expired) begin
          d.scl_oe_n = 1'b0;
          if (q.bitn == `BIT_LAST) begin
            d.status[`ST_BF] = 1'b0;
            done             = 1'b1;
            d.st             = S_IDLE;
          end else begin
            d.bitn     = q.bitn + 3'h1;
            d.sda_oe_n = bit_at(q.shift, q.bitn + 3'h1);
            d.brg      = brg_load;
            d.st       = S_TX_LO;
          end
        end
      end
      default: begin
        d.st = S_IDLE;
      end
    endcase

    // A collision outranks any step taken above
    if (coll) begin
      d.scl_oe_n         = 1'b1;
      d.sda_oe_n         = 1'b1;
      d.ctrl[`C_RSTART]  = 1'b0;
      d.ctrl[`C_STOP]    = 1'b0;
      d.status[`ST_BF]   = 1'b0;
      d.brg              = `BRG_ZERO;
      d.st               = S_IDLE;
    end
    // Disabling the port abandons any sequence and frees both lines
    if (!q.ctrl[`C_PEN]) begin
      d.status[`ST_STOP]  = 1'b0;
      d.status[`ST_START] = 1'b0;
      d.scl_oe_n          = 1'b1;
      d.sda_oe_n          = 1'b1;
      d.st                = S_IDLE;
    end

    // Read clears, but a new event in the same cycle survives
    if (rd_irq) begin
      d.irq_st = '0;
    end
    if (coll) begin
      d.irq_st[`I_BCOL] = 1'b1;
    end
    if (done) begin
      d.irq_st[`I_DONE] = 1'b1;
    end
    d.irq     = |(d.irq_st & d.irq_mask);
    // Ready from next state, so no write is taken while a write response waits, and no read while read data waits
    d.awready = !d.aw_hold && !d.bvalid;
    d.wready  = !d.w_hold && !d.bvalid;
    d.arready = !d.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q          <= '0;
      q.st       <= S_IDLE;
      q.status   <= `ST_RESET;
      q.scl_sy   <= 2'b11;
      q.sda_sy   <= 2'b11;
      q.scl_oe_n <= 1'b1;
      q.sda_oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready  = q.wready;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  // Pins are only ever pulled low; the enable decides
  assign scl_o         = 1'b0;
  assign sda_o         = 1'b0;
  assign scl_oe_n      = q.scl_oe_n;
  assign sda_oe_n      = q.sda_oe_n;
  assign irq           = q.irq;
endmodule : host_collision_brg
`default_nettype wire

// [tb/host_brg_assertions.sv]
// Checker on the host block's bus handshakes and pin drive
`timescale 1ns/1ps
`default_nettype none
module host_brg_assertions (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  // Pins and interrupt
  input wire logic        scl_o,
  input wire logic        sda_o,
  input wire logic        scl_oe_n,
  input wire logic        sda_oe_n,
  input wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  od_pins_a: assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("bus line driven high");
  rst_idle_a: assert property ($rose(aresetn) |-> scl_oe_n && sda_oe_n && !irq)
    else $error("lines or irq active after reset");
  // Needs reload of 3 or more, as software must keep
  scl_high_a: assert property ($rose(scl_oe_n) |=> scl_oe_n [*6])
    else $error("clock high phase too short");
  w_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##[0:1] s_axi_bvalid) else $error("write response missing");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  r_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0)
    else $error("refused read returns data");
  cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
  cover property ($rose(irq));
  cover property ($fell(sda_oe_n) && scl_oe_n);
endmodule : host_brg_assertions
`default_nettype wire

// [tb/bus_partner.sv]
// Other party on the two-wire bus, pulling lines low on command
`timescale 1ns/1ps
`default_nettype none
module bus_partner (
  // Clock and command
  input  wire logic       aclk,
  input  wire logic [1:0] mode,
  // Wire level and pulls
  input  wire logic       scl_w,
  output var  logic       scl_pull,
  output var  logic       sda_pull
);
  logic [3:0] hi_cnt = 4'h0;
  // Mode 1 sends a zero while clock is high
  assign sda_pull = (mode == 2'd1) && scl_w;
  // Mode 2 drags the clock low early and holds it
  always_ff @(posedge aclk) begin
    if (mode != 2'd2) hi_cnt <= 4'h0;
    else if (scl_w && hi_cnt != 4'h4) hi_cnt <= hi_cnt + 4'h1;
  end
  assign scl_pull = (hi_cnt == 4'h4);
endmodule : bus_partner
`default_nettype wire

// [tb/tb_host_collision_brg.sv]
// Self-checking bench for the host collision and baud block
`timescale 1ns/1ps
`default_nettype none
`include "host_brg_defines.svh"
module tb_host_collision_brg;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, mode;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        scl_o, sda_o, scl_oe_n, sda_oe_n, irq, scl_pull, sda_pull;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  // Pull-ups on both lines
  wire logic   scl_i = (scl_oe_n | scl_o) & ~scl_pull;
  wire logic   sda_i = (sda_oe_n | sda_o) & ~sda_pull;
  host_collision_brg i_host_collision_brg (.*);
  bus_partner i_bus_partner (.aclk, .mode, .scl_w(scl_i), .scl_pull, .sda_pull);
  initial forever #2.5 aclk = ~aclk;
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      n_mismatch++;
      $display("mismatch wait exp answer seen none");
      print_verdict();
    end
  endtask : tmo
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 60);
    s_axi_bready <= 1'b0;
    tmo(n, 60);
    chk("bresp", s_axi_bresp, `RESP_OKAY);
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 60);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    tmo(n, 60);
  endtask : axr
  // Waits for the interrupt, then reads and clears its cause
  task automatic ev(input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    tmo(n, 3000);
    axr(`A_IRQ_STAT, d, r);
    chk("irq stat", d, e);
    repeat (2) @(posedge aclk);
    chk("irq clear", irq, 1'b0);
  endtask : ev
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    axr(`A_STATUS, d, r);
    chk("status reset", d, 32'h0);
    axr(8'h3c, d, r);
    chk("unmapped resp", r, `RESP_SLV);
    axw(`A_STATUS, 32'hff);
    axr(`A_STATUS, d, r);
    chk("status write", d, 32'hc0);
    axw(`A_STATUS, 32'h0);
    axw(`A_SHIFT, 32'h5a);
    axr(`A_SHIFT, d, r);
    chk("shift dropped", d, 32'h0);
    $display("test regs done");
  endtask : t_regs
  task automatic t_shift;
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  bits;
    logic        last;
    int          t, nb, t0, t1, bad;
    axw(`A_RELOAD, 32'h3);
    axw(`A_CTRL, 32'h4);
    axw(`A_IRQ_MASK, 32'h0);
    axw(`A_SHIFT, 32'ha5);
    nb = 0;
    last = scl_i;
    for (t = 0; t < 600 && nb < 8; t++) begin
      @(posedge aclk);
      if (scl_i && !last) begin
        bits = {bits[6:0], sda_i};
        if (nb == 0) t0 = t;
        if (nb == 1) t1 = t;
        nb++;
      end
      last = scl_i;
    end
    tmo(t, 600);
    chk("bits out", bits, 8'ha5);
    chk("bus period", t1 - t0, 32'd16);
    repeat (200) @(posedge aclk);
    chk("irq masked", irq, 1'b0);
    axr(`A_IRQ_STAT, d, r);
    chk("done flag", d, 32'h2);
    bad = 0;
    for (t = 0; t < 40; t++) begin
      @(posedge aclk);
      if (scl_i !== 1'b0) bad++;
    end
    chk("clock held", bad, 32'd0);
    axw(`A_IRQ_MASK, 32'h3);
    $display("test shift done");
  endtask : t_shift
  // Repeated start (c=5) or stop (c=6) after a byte, partner in mode m
  task automatic t_seq(input logic [31:0] c, input logic [1:0] m, input logic col);
    logic [31:0] d;
    logic [1:0]  r;
    axw(`A_SHIFT, 32'hff);
    ev(32'h2);
    mode <= m;
    axw(`A_CTRL, c);
    ev(col ? 32'h1 : 32'h2);
    axr(`A_CTRL, d, r);
    chk("ctrl", d, 32'h4);
    chk("lines", {scl_oe_n, sda_oe_n}, (col || c == 32'h6) ? 2'b11 : 2'b00);
    axr(`A_STATUS, d, r);
    if (c == 32'h6) chk("stop seen", d & 32'h10, col ? 32'h0 : 32'h10);
    else if (!col) chk("start seen", d & 32'h18, 32'h08);
    mode <= 2'd0;
    @(posedge aclk);
    $display("test seq %0h mode %0d done", c, m);
  endtask : t_seq
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    mode = 2'd0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_shift();
    t_seq(32'h5, 2'd0, 1'b0);
    t_seq(32'h6, 2'd1, 1'b1);
    t_seq(32'h6, 2'd2, 1'b1);
    t_seq(32'h6, 2'd0, 1'b0);
    t_seq(32'h5, 2'd1, 1'b1);
    t_seq(32'h5, 2'd2, 1'b1);
    print_verdict();
  end
endmodule : tb_host_collision_brg
bind host_collision_brg host_brg_assertions i_host_brg_assertions (.*);
`default_nettype wire
